// *** rtl/aotc_pkg.sv ***
// Shared constants for the acceleration, time stamp and check-word output block
package aotc_pkg;
  localparam int          WORD_W        = 16;
  localparam int          ADDR_W        = 7;
  // Byte addresses on page zero
  localparam logic [6:0]  OFS_ACC_X_LO  = 7'h1C;
  localparam logic [6:0]  OFS_ACC_X_HI  = 7'h1E;
  localparam logic [6:0]  OFS_ACC_Y_LO  = 7'h20;
  localparam logic [6:0]  OFS_ACC_Y_HI  = 7'h22;
  localparam logic [6:0]  OFS_ACC_Z_LO  = 7'h24;
  localparam logic [6:0]  OFS_ACC_Z_HI  = 7'h26;
  localparam logic [6:0]  OFS_TSTAMP    = 7'h28;
  localparam logic [6:0]  OFS_CHK_LO    = 7'h2A;
  localparam logic [6:0]  OFS_CHK_HI    = 7'h2C;
  // Pin function control field, bits 8:7
  localparam int          PFC_SYNC_LSB  = 7;
  localparam logic [1:0]  PFC_PULSE     = 2'h3;
  // Range limit: +/-40 g is +/-32000 counts of 1.25 mg
  localparam logic [31:0] ACC_POS_MAX   = 32'h7D000000;
  localparam logic [31:0] ACC_NEG_MAX   = 32'h83000000;
  // Check word: reflected CRC-32
  localparam logic [31:0] CRC_POLY      = 32'hEDB88320;
  localparam logic [31:0] CRC_SEED      = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_XOROUT    = 32'hFFFFFFFF;
  localparam int          CRC_WORDS     = 15;
  localparam logic [3:0]  CRC_LAST      = 4'hE;
  localparam logic [15:0] TS_RESET      = 16'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  typedef enum logic [0:0] {AOTC_IDLE, AOTC_RUN} aotc_state_t;
endpackage

// *** rtl/aotc_sync.sv ***
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module aotc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("aotc_sync: W must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // aotc_sync

// *** rtl/aotc_crc32.sv ***
// CRC-32 engine taking one 16-bit word per enabled cycle
`timescale 1ns/1ps
module aotc_crc32 #(
  parameter bit BYTE_SWAP = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [15:0] word,
  output logic      [31:0] crc_q
);
  import aotc_pkg::*;

  // Low byte goes first unless swapped; bits of each byte LSB first
  function automatic logic [31:0] step16(input logic [31:0] c,
                                         input logic [15:0] w);
    logic [31:0] r;
    logic [15:0] d;
    r = c;
    d = BYTE_SWAP ? {w[7:0], w[15:8]} : w;
    for (int i = 0; i < 16; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q <= CRC_SEED;
    end else if (clear) begin
      crc_q <= CRC_SEED;
    end else if (en) begin
      crc_q <= step16(crc_q, word);
    end
  end
endmodule // aotc_crc32

// *** rtl/aotc_core.sv ***
// Output register set: acceleration, pulse time stamp and CRC-32 check words
`timescale 1ns/1ps
module aotc_core #(
  parameter int DEC_W     = 16,
  parameter bit BYTE_SWAP = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  smp_tick,
  input  wire logic [15:0]           sys_flags,
  input  wire logic [15:0]           temp_word,
  input  wire logic [31:0]           rate_x,
  input  wire logic [31:0]           rate_y,
  input  wire logic [31:0]           rate_z,
  input  wire logic [31:0]           accel_x,
  input  wire logic [31:0]           accel_y,
  input  wire logic [31:0]           accel_z,
  input  wire logic [1:0]            pin_function_control,
  input  wire logic [DEC_W-1:0]      decimation_setting,
  input  wire logic                  sync_pulse_pin,
  input  wire logic                  rd_en,
  input  wire logic [aotc_pkg::ADDR_W-1:0] rd_addr,
  output logic      [aotc_pkg::WORD_W-1:0] rd_data_q,
  output logic                       rd_valid_q,
  output logic                       data_ready_q,
  output logic                       update_busy,
  output logic                       overrun_q
);
  import aotc_pkg::*;

  if (DEC_W < 1 || DEC_W > 16) begin : g_chk
    $error("aotc_core: DEC_W must be 1 to 16");
  end

  // Pulse pin comes from outside this clock: synchronise, then find edge
  logic       pulse_s;
  logic       pulse_d_q;
  logic       pulse_edge;
  logic       pulse_mode;

  aotc_sync #(
    .W (1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (sync_pulse_pin),
    .q   (pulse_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_d_q <= 1'b0;
    end else begin
      pulse_d_q <= pulse_s;
    end
  end

  assign pulse_mode = (pin_function_control == PFC_PULSE);
  assign pulse_edge = pulse_mode && pulse_s && !pulse_d_q;

  // Sample counter since the last pulse; a tick in the clear cycle counts
  logic [15:0] ts_cnt_q;
  logic [15:0] ts_base;
  logic [15:0] ts_next;

  assign ts_base = pulse_edge ? TS_RESET : ts_cnt_q;
  assign ts_next = ts_base + {15'h0000, smp_tick};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_cnt_q <= TS_RESET;
    end else begin
      ts_cnt_q <= ts_next;
    end
  end

  // Decimation group tracking
  logic [DEC_W-1:0] dec_cnt_q;
  logic [15:0]      ts_first_q;
  logic [15:0]      ts_first;
  logic             group_end;

  assign group_end = smp_tick && (dec_cnt_q >= decimation_setting);
  assign ts_first  = (dec_cnt_q == '0) ? ts_next : ts_first_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_cnt_q <= '0;
    end else if (group_end) begin
      dec_cnt_q <= '0;
    end else if (smp_tick) begin
      dec_cnt_q <= dec_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_first_q <= TS_RESET;
    end else if (smp_tick && dec_cnt_q == '0) begin
      ts_first_q <= ts_next;
    end
  end

  // Clamp a result to the +/-40 g span
  function automatic logic [31:0] clamp40(input logic [31:0] v);
    if ($signed(v) > $signed(ACC_POS_MAX)) begin
      return ACC_POS_MAX;
    end else if ($signed(v) < $signed(ACC_NEG_MAX)) begin
      return ACC_NEG_MAX;
    end
    return v;
  endfunction

  // Snapshot of the fifteen check-word sources, in check order
  logic [15:0] snap_q [CRC_WORDS];
  logic [31:0] acc_x_c;
  logic [31:0] acc_y_c;
  logic [31:0] acc_z_c;
  logic        start;

  assign acc_x_c = clamp40(accel_x);
  assign acc_y_c = clamp40(accel_y);
  assign acc_z_c = clamp40(accel_z);

  aotc_state_t state_q;
  logic [3:0]  idx_q;

  assign start       = group_end && (state_q == AOTC_IDLE);
  assign update_busy = (state_q == AOTC_RUN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CRC_WORDS; i++) begin
        snap_q[i] <= WORD_RESET;
      end
    end else if (start) begin
      snap_q[0]  <= sys_flags;
      snap_q[1]  <= temp_word;
      snap_q[2]  <= rate_x[15:0];
      snap_q[3]  <= rate_x[31:16];
      snap_q[4]  <= rate_y[15:0];
      snap_q[5]  <= rate_y[31:16];
      snap_q[6]  <= rate_z[15:0];
      snap_q[7]  <= rate_z[31:16];
      snap_q[8]  <= acc_x_c[15:0];
      snap_q[9]  <= acc_x_c[31:16];
      snap_q[10] <= acc_y_c[15:0];
      snap_q[11] <= acc_y_c[31:16];
      snap_q[12] <= acc_z_c[15:0];
      snap_q[13] <= acc_z_c[31:16];
      snap_q[14] <= ts_first;
    end
  end

  // One word per cycle into the engine; a new group during a run is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= AOTC_IDLE;
      idx_q   <= 4'h0;
    end else begin
      unique case (state_q)
        AOTC_IDLE: begin
          idx_q <= 4'h0;
          if (start) begin
            state_q <= AOTC_RUN;
          end
        end
        AOTC_RUN: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == CRC_LAST) begin
            state_q <= AOTC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= group_end && (state_q == AOTC_RUN);
    end
  end

  logic [31:0] crc_raw;
  logic        feed;
  logic        last;

  assign feed = (state_q == AOTC_RUN);
  assign last = feed && (idx_q == CRC_LAST);

  aotc_crc32 #(
    .BYTE_SWAP (BYTE_SWAP)
  ) u_crc (
    .clk   (clk),
    .rst   (rst),
    .clear (start),
    .en    (feed),
    .word  (snap_q[idx_q]),
    .crc_q (crc_raw)
  );

  // Publish stage: becomes visible only once the check word is complete
  logic [15:0] pub_q [CRC_WORDS];
  logic [31:0] chk_q;
  logic        pub_go_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pub_go_q <= 1'b0;
    end else begin
      pub_go_q <= last;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CRC_WORDS; i++) begin
        pub_q[i] <= WORD_RESET;
      end
      chk_q <= 32'h00000000;
    end else if (pub_go_q) begin
      pub_q <= snap_q;
      chk_q <= crc_raw ^ CRC_XOROUT;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_ready_q <= 1'b0;
    end else begin
      data_ready_q <= pub_go_q;
    end
  end

  // Register read port; odd byte addresses read the same word
  function automatic logic [15:0] reg_read(input logic [6:0] a);
    unique case ({a[6:1], 1'b0})
      OFS_ACC_X_LO: return pub_q[8];
      OFS_ACC_X_HI: return pub_q[9];
      OFS_ACC_Y_LO: return pub_q[10];
      OFS_ACC_Y_HI: return pub_q[11];
      OFS_ACC_Z_LO: return pub_q[12];
      OFS_ACC_Z_HI: return pub_q[13];
      OFS_TSTAMP:   return pub_q[14];
      OFS_CHK_LO:   return chk_q[15:0];
      OFS_CHK_HI:   return chk_q[31:16];
      default:      return WORD_RESET;
    endcase
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q  <= WORD_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= reg_read(rd_addr);
      end
    end
  end
endmodule // aotc_core

// *** dv/aotc_core_properties.sv ***
// Port-level properties of the output register block
`timescale 1ns/1ps
module aotc_core_properties #(
  parameter int DEC_W = 16
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             smp_tick,
  input wire logic [DEC_W-1:0] decimation_setting,
  input wire logic             rd_en,
  input wire logic [6:0]       rd_addr,
  input wire logic [15:0]      rd_data_q,
  input wire logic             rd_valid_q,
  input wire logic             data_ready_q,
  input wire logic             update_busy,
  input wire logic             overrun_q
);
  logic [4:0] busy_cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 5'h00;
    end else begin
      busy_cnt_q <= update_busy ? busy_cnt_q + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_crc_done;
    $fell(update_busy);
  endsequence
  sequence s_publish;
    ##[1:3] data_ready_q;
  endsequence
  a_read_answer: assert property (rd_en |=> rd_valid_q) else $error("no read answer");
  a_valid_cause: assert property (rd_valid_q |-> $past(rd_en)) else $error("stray valid");
  a_data_holds: assert property (!rd_valid_q |-> $stable(rd_data_q)) else $error("data moved");
  a_unmapped_zero: assert property (rd_en && !(rd_addr[6:1] inside {[6'h0E:6'h16]}) |=>
    rd_data_q == 16'h0000) else $error("unmapped not zero");
  a_crc_length: assert property (s_crc_done |-> busy_cnt_q == 5'h0F) else $error("busy length");
  a_ready_follows: assert property (s_crc_done |-> s_publish) else $error("no ready");
  a_ready_pulse: assert property (data_ready_q |=> !data_ready_q) else $error("ready too long");
  a_busy_no_ready: assert property (update_busy |-> !data_ready_q) else $error("ready in busy");
  a_overrun_cause: assert property (overrun_q |-> $past(update_busy) && $past(smp_tick))
    else $error("stray overrun");
  a_tick_starts: assert property (smp_tick && decimation_setting == '0 && !update_busy && !data_ready_q
    |-> ##[1:2] update_busy) else $error("tick ignored");
endmodule // aotc_core_properties

bind aotc_core aotc_core_properties #(.DEC_W(DEC_W)) u_props (.clk(clk), .rst(rst), .smp_tick(smp_tick),
  .decimation_setting(decimation_setting), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
  .rd_valid_q(rd_valid_q), .data_ready_q(data_ready_q), .update_busy(update_busy), .overrun_q(overrun_q));

// *** dv/aotc_host.sv ***
// Host model reading the output registers over the parallel port
`timescale 1ns/1ps
module aotc_host (
  input  wire logic        clk,
  output logic             rd_en,
  output logic [6:0]       rd_addr,
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
  end
  // Idle address is inverted so a stale address never looks like a request
  task automatic read(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    @(posedge clk);
    d = rd_data_q;
    v = rd_valid_q;
  endtask
endmodule // aotc_host

// *** dv/tb.sv ***
// Self-checking bench for the output register block
`timescale 1ns/1ps
module tb;
  import aotc_pkg::*;
  logic        clk, rst, smp_tick, sync_pulse_pin, rd_en, rd_valid_q, data_ready_q, update_busy, overrun_q;
  logic [15:0] sys_flags, temp_word, decimation_setting, rd_data_q;
  logic [31:0] rate_x, rate_y, rate_z, accel_x, accel_y, accel_z;
  logic [1:0]  pin_function_control;
  logic [6:0]  rd_addr;
  logic        ovr_seen;
  int          mismatches, total_checks, cycles;
  aotc_core dut (
    .clk                  (clk),
    .rst                  (rst),
    .smp_tick             (smp_tick),
    .sys_flags            (sys_flags),
    .temp_word            (temp_word),
    .rate_x               (rate_x),
    .rate_y               (rate_y),
    .rate_z               (rate_z),
    .accel_x              (accel_x),
    .accel_y              (accel_y),
    .accel_z              (accel_z),
    .pin_function_control (pin_function_control),
    .decimation_setting   (decimation_setting),
    .sync_pulse_pin       (sync_pulse_pin),
    .rd_en                (rd_en),
    .rd_addr              (rd_addr),
    .rd_data_q            (rd_data_q),
    .rd_valid_q           (rd_valid_q),
    .data_ready_q         (data_ready_q),
    .update_busy          (update_busy),
    .overrun_q            (overrun_q)
  );
  aotc_host host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Bounded so a stuck update cannot hang the run
  always @(posedge clk) begin
    cycles++;
    if (overrun_q === 1'b1) ovr_seen <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(logic [6:0] a, logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.read(a, d, v);
    check("read valid", {15'h0000, v}, 16'h0001);
    check($sformatf("addr %h", a), d, exp);
  endtask
  function automatic logic [31:0] clampv(logic [31:0] v);
    if ($signed(v) > $signed(ACC_POS_MAX)) return ACC_POS_MAX;
    if ($signed(v) < $signed(ACC_NEG_MAX)) return ACC_NEG_MAX;
    return v;
  endfunction
  task automatic verify(logic [15:0] ts);
    logic [15:0] w[15];
    logic [31:0] ax, ay, az, c;
    ax = clampv(accel_x);
    ay = clampv(accel_y);
    az = clampv(accel_z);
    w = '{sys_flags, temp_word, rate_x[15:0], rate_x[31:16], rate_y[15:0], rate_y[31:16], rate_z[15:0],
          rate_z[31:16], ax[15:0], ax[31:16], ay[15:0], ay[31:16], az[15:0], az[31:16], ts};
    c = CRC_SEED;
    foreach (w[i]) for (int b = 0; b < 16; b++) c = (c >> 1) ^ ((c[0] ^ w[i][b]) ? CRC_POLY : 32'h0);
    c = c ^ CRC_XOROUT;
    for (int i = 0; i < 7; i++) rd_chk(OFS_ACC_X_LO + 7'(2 * i), w[8 + i]);
    rd_chk(OFS_ACC_X_HI + 7'h01, w[9]);
    rd_chk(OFS_CHK_LO, c[15:0]);
    rd_chk(OFS_CHK_HI, c[31:16]);
  endtask
  // One frame of the 100 ns link pulse; the line rests low between frames
  task automatic pulse();
    @(posedge clk) sync_pulse_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sync_pulse_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk) smp_tick <= 1'b1;
      @(posedge clk) smp_tick <= 1'b0;
      repeat (19) @(posedge clk);
    end
  endtask
  initial begin
    rst = 1'b1;
    smp_tick = 1'b0;
    sync_pulse_pin = 1'b0;
    ovr_seen = 1'b0;
    sys_flags = 16'h0000;
    temp_word = 16'h083A;
    rate_x = 32'hFFF70000;
    rate_y = 32'hFFFE0000;
    rate_z = 32'h00010000;
    accel_x = 32'h00035001;
    accel_y = 32'h0015E00A;
    accel_z = 32'h0320C009;
    pin_function_control = PFC_PULSE;
    decimation_setting = 16'h0003;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(7'h1C + 7'(2 * i), 16'h0000);
    $display("test reset_and_unmapped done");
    pulse();
    ticks(4);
    verify(16'h0001);
    ticks(4);
    verify(16'h0005);
    accel_x <= 32'h7FFFFFFF;
    accel_y <= 32'h80000000;
    ticks(4);
    verify(16'h0009);
    $display("test decimated_stamp_and_clamp done");
    pulse();
    ticks(4);
    verify(16'h0001);
    decimation_setting <= 16'h0000;
    ticks(1);
    $display("test repeat_pulse done");
    @(posedge clk) smp_tick <= 1'b1;
    @(posedge clk) smp_tick <= 1'b0;
    @(posedge clk) smp_tick <= 1'b1;
    @(posedge clk) smp_tick <= 1'b0;
    repeat (20) @(posedge clk);
    check("overrun", {15'h0000, ovr_seen}, 16'h0001);
    verify(16'h0006);
    $display("test overrun done");
    // Outside pulse mode the pulse must not clear the stamp
    pin_function_control <= 2'h0;
    pulse();
    ticks(1);
    verify(16'h0008);
    $display("test pulse_ignored done");
    // Reset in mid-run: published words fall back to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_TSTAMP, 16'h0000);
    rd_chk(OFS_CHK_HI, 16'h0000);
    ticks(1);
    verify(16'h0001);
    $display("test reset_again done");
    report_and_stop();
  end
endmodule // tb
